// ==== hw/tmu_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef TMU_MAP_SVH
`define TMU_MAP_SVH
`define TMU_CTRL0_OFS 12'h000
`define TMU_CTRL1_OFS 12'h004
`define TMU_CTRL2_OFS 12'h008
`define TMU_CTRL3_OFS 12'h00C
`define TMU_MATCH0_OFS 12'h010
`define TMU_MATCH1_OFS 12'h014
`define TMU_MATCH2_OFS 12'h018
`define TMU_MATCH3_OFS 12'h01C
`define TMU_COUNT0_OFS 12'h020
`define TMU_COUNT1_OFS 12'h024
`define TMU_COUNT2_OFS 12'h028
`define TMU_COUNT3_OFS 12'h02C
`define TMU_STATUS_OFS 12'h030
`define TMU_MASK_OFS 12'h034
`define TMU_WDCTRL_OFS 12'h038
`define TMU_WDFEED_OFS 12'h03C
`define TMU_WDCOUNT_OFS 12'h040
`define TMU_CLKSEL_OFS 12'h044
// control fields
`define TMU_CTRL_EN_BIT 0
`define TMU_CTRL_FREE_BIT 1
`define TMU_CTRL_CHAIN_BIT 2
`define TMU_WD_EN_BIT 0
`define TMU_WD_FEED_KEY 32'h0000A5A5
// reset values
`define TMU_MASK_RST 4'h0
`define TMU_WD_LIMIT_RST 10'h3FF
`define TMU_WD_IRQ_RST 10'h300
`define TMU_CLKSEL_RST 2'h0
// timing: slow oscillator in Hz, tick in ms, system clock in Hz
`define TMU_SLOW_HZ 365000
`define TMU_SYS_HZ 20000000
`define TMU_TICK_MS 10
`define TMU_TICK_CYC (`TMU_SYS_HZ / 1000 * `TMU_TICK_MS)
`define TMU_SLOW_DIV_T 2
`define TMU_SLOW_DIV_W 128
`endif

// ==== hw/tmu_pkg.sv ====
// types for the timer and watchdog unit
package tmu_pkg;
   typedef enum logic [1:0] {
      TMU_BUS_IDLE,
      TMU_BUS_DATA
   } tmu_bus_state_t;
   typedef logic [31:0] tmu_word_t;
endpackage

// ==== hw/tmu_if.sv ====
// carrier between the unit and its tick generator
`timescale 1ns/1ns
interface tmu_tick_if;
   logic slow_edge;
   logic [1:0] clk_sel;
   logic t_tick;
   logic w_tick;
   logic sys_tick;
   modport gen (input slow_edge, input clk_sel, output t_tick,
                output w_tick, output sys_tick);
   modport use_side (output slow_edge, output clk_sel, input t_tick,
                     input w_tick, input sys_tick);
endinterface

// ==== hw/tmu_tickgen.sv ====
// prescalers for the slow timers, watchdog and tick
`timescale 1ns/1ns
`include "tmu_map.svh"
module tmu_tickgen
   import tmu_pkg::*;
(
   input wire logic clk_i,  // system clock
   input wire logic rstn_i, // sync reset, low
   input wire logic ce_i,   // clock enable
   tmu_tick_if.gen tk       // tick carrier
);
   logic [6:0] slow_cnt;
   logic [17:0] tick_cnt;
   localparam logic [17:0] TICK_LAST = 18'(`TMU_TICK_CYC - 1);

   // slow clock divided by two and by 128
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         slow_cnt <= 7'h00;
      end else if (ce_i && tk.slow_edge) begin
         slow_cnt <= slow_cnt + 7'h01;
      end
   end
   assign tk.t_tick = ce_i && tk.slow_edge && slow_cnt[0];
   assign tk.w_tick = ce_i && tk.slow_edge && (slow_cnt == 7'h7F);

   // periodic tick exception every 10 ms at 20 MHz
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         tick_cnt <= 18'h00000;
      end else if (ce_i) begin
         tick_cnt <= (tick_cnt == TICK_LAST) ? 18'h00000 : tick_cnt + 18'h1;
      end
   end
   assign tk.sys_tick = ce_i && (tick_cnt == TICK_LAST);
endmodule

// ==== hw/tmu_top.sv ====
// four timers, watchdog and AHB-Lite register slave
`timescale 1ns/1ns
`include "tmu_map.svh"
module tmu_top
   import tmu_pkg::*;
(
   input wire logic REF_CLK_I,      // system clock, 20 MHz
   input wire logic RSTN_I,         // sync reset, active low
   input wire logic CE_I,           // clock enable
   input wire logic SLOW_CLK_I,     // slow oscillator pin
   input wire logic HSEL_I,         // slave select
   input wire logic [31:0] HADDR_I, // address
   input wire logic [1:0] HTRANS_I, // transfer type
   input wire logic HWRITE_I,       // write
   input wire logic [2:0] HSIZE_I,  // size
   input wire logic HREADY_I,       // bus ready
   input wire logic [31:0] HWDATA_I, // write data
   output logic [31:0] HRDATA_O,    // read data
   output logic HREADYOUT_O,        // slave ready
   output logic HRESP_O,            // response
   output logic TIMER_OUT_O,        // shared timer line
   output logic TIMER_IRQ_O,        // timer interrupt
   output logic WD_NMI_O,           // watchdog to nmi
   output logic WD_RESET_O,         // system reset request
   output logic SYS_TICK_O          // periodic tick pulse
);
   tmu_tick_if tk ();
   tmu_bus_state_t bus_state;
   logic [2:0] slow_sync;
   logic [11:0] b_addr;
   logic b_write;
   logic [2:0] ctrl [4];
   tmu_word_t match [4];
   tmu_word_t count [4];
   logic [3:0] running;
   logic [3:0] flag;
   logic [3:0] mask;
   logic [3:0] hit;
   logic [3:0] step;
   logic [3:0] next_clr;
   logic [1:0] clk_sel;
   logic [1:0] fast_div;
   logic fast_tick;
   logic wd_en;
   logic [9:0] wd_cnt;
   logic [9:0] wd_limit;
   logic [9:0] wd_irq_at;
   logic wd_nmi;
   logic wd_feed;
   logic wr;
   logic [31:0] next_rdata;

   // slow oscillator pin through three flops, edge from stages two and three
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         slow_sync <= 3'h0;
      end else if (CE_I) begin
         slow_sync <= {slow_sync[1:0], SLOW_CLK_I};
      end
   end
   assign tk.slow_edge = slow_sync[1] && !slow_sync[2];
   assign tk.clk_sel = clk_sel;

   tmu_tickgen u_tick (
      .clk_i(REF_CLK_I),
      .rstn_i(RSTN_I),
      .ce_i(CE_I),
      .tk(tk)
   );

   // fast timer tick follows the selected system clock rate
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         fast_div <= 2'h0;
      end else if (CE_I) begin
         fast_div <= fast_div + 2'h1;
      end
   end
   assign fast_tick = CE_I && ((clk_sel == 2'h1) ? fast_div[0] :
                      (clk_sel == 2'h2) ? (fast_div == 2'h3) : 1'b1);

   // address phase capture and data phase tracking
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         bus_state <= TMU_BUS_IDLE;
         b_addr <= 12'h000;
         b_write <= 1'b0;
      end else if (CE_I) begin
         if (HREADY_I && HSEL_I && HTRANS_I[1]) begin
            bus_state <= TMU_BUS_DATA;
            b_addr <= HADDR_I[11:0];
            b_write <= HWRITE_I;
         end else if (HREADY_I) begin
            bus_state <= TMU_BUS_IDLE;
         end
      end
   end
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   assign wr = CE_I && (bus_state == TMU_BUS_DATA) && b_write;

   // match detection and count steps per timer
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         hit[i] = running[i] && (count[i] == match[i]);
      end
      step[0] = tk.t_tick;
      step[1] = ctrl[1][`TMU_CTRL_CHAIN_BIT] ? (hit[0] && step[0])
                : tk.t_tick;
      step[2] = fast_tick;
      step[3] = fast_tick;
   end

   // timer control and match registers
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         for (int i = 0; i < 4; i++) begin
            ctrl[i] <= 3'h0;
            match[i] <= 32'h00000000;
         end
         mask <= `TMU_MASK_RST;
         clk_sel <= `TMU_CLKSEL_RST;
      end else if (wr) begin
         if (b_addr == `TMU_CTRL0_OFS) begin
            ctrl[0] <= {1'b0, HWDATA_I[1:0]};
         end else if (b_addr == `TMU_CTRL1_OFS) begin
            ctrl[1] <= HWDATA_I[2:0];
         end else if (b_addr == `TMU_CTRL2_OFS) begin
            ctrl[2] <= {1'b0, HWDATA_I[1:0]};
         end else if (b_addr == `TMU_CTRL3_OFS) begin
            ctrl[3] <= {1'b0, HWDATA_I[1:0]};
         end else if (b_addr == `TMU_MATCH0_OFS) begin
            match[0] <= {20'h00000, HWDATA_I[11:0]};
         end else if (b_addr == `TMU_MATCH1_OFS) begin
            match[1] <= {20'h00000, HWDATA_I[11:0]};
         end else if (b_addr == `TMU_MATCH2_OFS) begin
            match[2] <= HWDATA_I;
         end else if (b_addr == `TMU_MATCH3_OFS) begin
            match[3] <= HWDATA_I;
         end else if (b_addr == `TMU_MASK_OFS) begin
            mask <= HWDATA_I[3:0];
         end else if (b_addr == `TMU_CLKSEL_OFS) begin
            clk_sel <= HWDATA_I[1:0];
         end
      end
   end

   // counters: start on enable write, stop or restart at match
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         for (int i = 0; i < 4; i++) begin
            count[i] <= 32'h00000000;
         end
         running <= 4'h0;
      end else if (CE_I) begin
         for (int i = 0; i < 4; i++) begin
            if (wr && b_addr == (`TMU_CTRL0_OFS + 12'(4 * i))) begin
               running[i] <= HWDATA_I[`TMU_CTRL_EN_BIT];
               count[i] <= 32'h00000000;
            end else if (running[i] && step[i]) begin
               if (hit[i]) begin
                  count[i] <= 32'h00000000;
                  running[i] <= ctrl[i][`TMU_CTRL_FREE_BIT];
               end else if (i < 2) begin
                  count[i] <= {20'h00000, count[i][11:0] + 12'h001};
               end else begin
                  count[i] <= count[i] + 32'h00000001;
               end
            end
         end
      end
   end

   // time-out flags, set wins over a software clear
   always_comb begin
      next_clr = (wr && b_addr == `TMU_STATUS_OFS) ? HWDATA_I[3:0] : 4'h0;
   end
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         flag <= 4'h0;
      end else if (CE_I) begin
         flag <= (flag & ~next_clr) | (hit & step);
      end
   end

   // watchdog enable, feed and count on the slow clock over 128
   assign wd_feed = wr && b_addr == `TMU_WDFEED_OFS &&
                    HWDATA_I == `TMU_WD_FEED_KEY;
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         wd_en <= 1'b0;
         wd_cnt <= 10'h000;
         wd_limit <= `TMU_WD_LIMIT_RST;
         wd_irq_at <= `TMU_WD_IRQ_RST;
         wd_nmi <= 1'b0;
      end else if (CE_I) begin
         if (WD_RESET_O) begin
            wd_en <= 1'b0;
            wd_cnt <= 10'h000;
            wd_nmi <= 1'b0;
         end else if (wr && b_addr == `TMU_WDCTRL_OFS) begin
            wd_en <= HWDATA_I[`TMU_WD_EN_BIT];
            wd_limit <= HWDATA_I[25:16];
            wd_irq_at <= HWDATA_I[13:4];
            wd_cnt <= 10'h000;
         end else if (wd_feed) begin
            wd_cnt <= 10'h000;
            wd_nmi <= 1'b0;
         end else if (wd_en && tk.w_tick) begin
            wd_cnt <= wd_cnt + 10'h001;
            if (wd_cnt + 10'h001 == wd_irq_at) begin
               wd_nmi <= 1'b1;
            end
         end
      end
   end

   // watchdog reset pulse once the limit is reached
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         WD_RESET_O <= 1'b0;
      end else if (CE_I) begin
         WD_RESET_O <= wd_en && !WD_RESET_O && wd_cnt == wd_limit &&
                       !wd_feed;
      end
   end

   // output lines
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         TIMER_OUT_O <= 1'b0;
         TIMER_IRQ_O <= 1'b0;
         WD_NMI_O <= 1'b0;
         SYS_TICK_O <= 1'b0;
      end else if (CE_I) begin
         TIMER_OUT_O <= |(hit & step);
         TIMER_IRQ_O <= |(flag & mask);
         WD_NMI_O <= wd_nmi;
         SYS_TICK_O <= tk.sys_tick;
      end
   end

   // read mux
   always_comb begin
      next_rdata = 32'h00000000;
      if (b_addr[11:4] == 8'h00) begin
         next_rdata = {29'h00000000, ctrl[b_addr[3:2]]};
      end else if (b_addr[11:4] == 8'h01) begin
         next_rdata = match[b_addr[3:2]];
      end else if (b_addr[11:4] == 8'h02) begin
         next_rdata = count[b_addr[3:2]];
      end else if (b_addr == `TMU_STATUS_OFS) begin
         next_rdata = {28'h0000000, flag};
      end else if (b_addr == `TMU_MASK_OFS) begin
         next_rdata = {28'h0000000, mask};
      end else if (b_addr == `TMU_WDCTRL_OFS) begin
         next_rdata = {6'h00, wd_limit, 2'h0, wd_irq_at, 3'h0, wd_en};
      end else if (b_addr == `TMU_WDCOUNT_OFS) begin
         next_rdata = {22'h000000, wd_cnt};
      end else if (b_addr == `TMU_CLKSEL_OFS) begin
         next_rdata = {30'h00000000, clk_sel};
      end
   end
   assign HRDATA_O = (bus_state == TMU_BUS_DATA && !b_write) ?
                     next_rdata : 32'h00000000;
endmodule

// ==== sim/tmu_top_asserts.sv ====
// port assertions for the timer and watchdog unit
`timescale 1ns/1ns
`include "tmu_map.svh"
module tmu_top_asserts (
   input wire logic REF_CLK_I, // clock
   input wire logic RSTN_I, // reset, low
   input wire logic CE_I, // enable
   input wire logic SLOW_CLK_I, // slow pin
   input wire logic HSEL_I, // select
   input wire logic [31:0] HADDR_I, // address
   input wire logic [1:0] HTRANS_I, // transfer
   input wire logic HWRITE_I, // write
   input wire logic [2:0] HSIZE_I, // size
   input wire logic HREADY_I, // ready in
   input wire logic [31:0] HWDATA_I, // write data
   input wire logic [31:0] HRDATA_O, // read data
   input wire logic HREADYOUT_O, // ready out
   input wire logic HRESP_O, // response
   input wire logic TIMER_OUT_O, // timer line
   input wire logic TIMER_IRQ_O, // timer irq
   input wire logic WD_NMI_O, // nmi
   input wire logic WD_RESET_O, // reset request
   input wire logic SYS_TICK_O // tick
);
   logic rd_ph;
   logic wr_ph;
   logic [11:0] ad_ph;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   // data phase tracking
   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         rd_ph <= 1'b0;
         wr_ph <= 1'b0;
      end else begin
         rd_ph <= HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
         wr_ph <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
      end
   end
   // address held for the data phase
   always_ff @(posedge REF_CLK_I) begin
      if (HREADY_I) begin
         ad_ph <= HADDR_I[11:0];
      end
   end
   a_ready_high: assert property (HREADYOUT_O && !HRESP_O)
      else $error("slave not ready or not okay");
   a_rdata_idle: assert property (!rd_ph |-> HRDATA_O == 32'h0)
      else $error("read data outside data phase");
   a_unmapped_zero: assert property (
      rd_ph && ad_ph > `TMU_CLKSEL_OFS |-> HRDATA_O == 32'h0)
      else $error("unmapped read not zero");
   a_wdrst_once: assert property (
      $rose(WD_RESET_O) |=> !WD_RESET_O [*8])
      else $error("watchdog reset repeated");
   a_tick_pulse: assert property (SYS_TICK_O |=> !SYS_TICK_O [*8])
      else $error("tick pulse too long");
   a_mask_kills_irq: assert property (
      wr_ph && ad_ph == `TMU_MASK_OFS && HWDATA_I[3:0] == 4'h0
      |=> ##1 !TIMER_IRQ_O)
      else $error("masked irq still high");
   a_feed_clears: assert property (
      wr_ph && ad_ph == `TMU_WDFEED_OFS && HWDATA_I == `TMU_WD_FEED_KEY
      |=> ##1 !WD_NMI_O)
      else $error("feed left nmi high");
   a_reset_quiet: assert property (disable iff (1'b0) !RSTN_I |=>
      !(TIMER_OUT_O | TIMER_IRQ_O | WD_NMI_O | WD_RESET_O | SYS_TICK_O))
      else $error("output active after reset");
   c_irq: cover property ($rose(TIMER_IRQ_O));
   c_nmi: cover property ($rose(WD_NMI_O));
   c_wdrst: cover property ($rose(WD_RESET_O));
   c_tout: cover property (TIMER_OUT_O);
endmodule

// ==== sim/tmu_cpu_model.sv ====
// bus master model standing in for the processor core
`timescale 1ns/1ns
`include "tmu_map.svh"
module tmu_cpu_model (
   input wire logic clk_i, // bus clock
   input wire logic hready_i, // bus ready
   input wire logic [31:0] hrdata_i, // read data
   output logic [31:0] haddr_o, // address
   output logic [1:0] htrans_o, // transfer type
   output logic hwrite_o, // write
   output logic [31:0] hwdata_o // write data
);
   // idle bus at time zero
   initial begin
      haddr_o = 32'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hwdata_o = 32'h0;
   end
   // one single word, held until ready in both phases
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      haddr_o <= {20'h0, a};
      htrans_o <= 2'h2;
      hwrite_o <= w;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      htrans_o <= 2'h0;
      hwdata_o <= wd;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      rd = hrdata_i;
      hwdata_o <= ~wd;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      xfer(1'b0, a, 32'h0, d);
   endtask
   // single reload of the watchdog with the feed key
   task automatic feed;
      wr(`TMU_WDFEED_OFS, `TMU_WD_FEED_KEY);
   endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the timer and watchdog unit
`timescale 1ns/1ns
`include "tmu_map.svh"
module tb_top
   import tmu_pkg::*;
;
   localparam int STEP_NS = 2 * 2740;
   logic clk, rstn, slow, hwrite, hready, hresp, ce;
   logic t_out, t_irq, nmi, wrst, tick;
   logic [31:0] haddr, hwdata, hrdata, m;
   logic [1:0] htrans;
   int mismatches, n_checks, seed, g, n;
   time t0;
   tmu_word_t rv;
   logic [11:0] rst_a[$] = '{12'h034, 12'h038, 12'h044, 12'h040, 12'h100};
   logic [31:0] rst_v[$] = '{32'h0, 32'h03FF3000, 32'h0, 32'h0, 32'h0};
   tmu_top i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
      .SLOW_CLK_I(slow), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hready),
      .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
      .HRESP_O(hresp), .TIMER_OUT_O(t_out), .TIMER_IRQ_O(t_irq),
      .WD_NMI_O(nmi), .WD_RESET_O(wrst), .SYS_TICK_O(tick));
   tmu_cpu_model i_cpu (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
      .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
      .hwdata_o(hwdata));
   // system clock and slow oscillator
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      slow = 1'b0;
      forever #1370 slow = ~slow;
   end
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_sim;
      if (mismatches == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // bounded wait for an output to go high
   task automatic wait_hi(ref logic s, input int lim);
      int k;
      k = 0;
      while (s !== 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
      chk("wait", {31'h0, s}, 32'h1);
   endtask
   // cycles between two pulses of the shared line
   task automatic gap(output int c);
      wait_hi(t_out, 5000);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (t_out !== 1'b1 && c < 5000);
   endtask
   initial begin
      #4000000;
      mismatches++;
      end_sim;
   end
   initial begin
      seed = 14616;
      ce = 1'b1;
      rstn = 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      // reset values and an unmapped read
      foreach (rst_a[i]) begin
         i_cpu.rd(rst_a[i], rv);
         chk("reset value", rv, rst_v[i]);
      end
      // single-shot fast timer, masked then unmasked, then cleared
      rv = $random(seed);
      m = {29'h0, rv[2:0]} + 32'h2;
      i_cpu.wr(`TMU_MATCH2_OFS, m);
      i_cpu.wr(`TMU_CTRL2_OFS, 32'h1);
      wait_hi(t_out, 200);
      n = 0;
      repeat (4 * 12) begin
         @(posedge clk);
         if (t_out !== 1'b0) n++;
      end
      chk("single shot", n, 32'h0);
      i_cpu.rd(`TMU_STATUS_OFS, rv);
      chk("flag", rv, 32'h4);
      chk("irq masked", {31'h0, t_irq}, 32'h0);
      i_cpu.wr(`TMU_MASK_OFS, 32'h4);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, t_irq}, 32'h1);
      i_cpu.wr(`TMU_STATUS_OFS, 32'h4);
      repeat (2) @(posedge clk);
      chk("irq cleared", {31'h0, t_irq}, 32'h0);
      // free-running fast timer at each system clock rate
      for (int s = 0; s < 3; s++) begin
         rv = $random(seed);
         m = {28'h0, rv[3:0]};
         i_cpu.wr(`TMU_CLKSEL_OFS, s);
         i_cpu.wr(`TMU_MATCH3_OFS, m);
         i_cpu.wr(`TMU_CTRL3_OFS, 32'h3);
         gap(g);
         chk("period", g, (m + 1) << s);
         i_cpu.wr(`TMU_CTRL3_OFS, 32'h0);
      end
      // slow timer 1 chained onto free-running slow timer 0
      i_cpu.wr(`TMU_CLKSEL_OFS, 32'h0);
      i_cpu.wr(`TMU_STATUS_OFS, 32'hF);
      i_cpu.wr(`TMU_MASK_OFS, 32'h2);
      i_cpu.wr(`TMU_MATCH0_OFS, 32'h2);
      i_cpu.wr(`TMU_MATCH1_OFS, 32'h1);
      i_cpu.wr(`TMU_CTRL1_OFS, 32'h5);
      i_cpu.wr(`TMU_CTRL0_OFS, 32'h3);
      t0 = $time;
      wait_hi(t_irq, 2000);
      g = int'(($time - t0) / STEP_NS);
      chk("chain span", {31'h0, g >= 5 && g <= 7}, 32'h1);
      i_cpu.rd(`TMU_STATUS_OFS, rv);
      chk("chain flags", rv, 32'h3);
      i_cpu.wr(`TMU_CTRL0_OFS, 32'h0);
      i_cpu.wr(`TMU_CTRL1_OFS, 32'h0);
      i_cpu.wr(`TMU_MASK_OFS, 32'h0);
      i_cpu.wr(`TMU_STATUS_OFS, 32'hF);
      // clock enable low freezes the counters for 20 edges
      i_cpu.wr(`TMU_MATCH3_OFS, 32'hFFFFFFFF);
      i_cpu.wr(`TMU_CTRL3_OFS, 32'h3);
      i_cpu.rd(`TMU_COUNT3_OFS, m);
      t0 = $time;
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      i_cpu.rd(`TMU_COUNT3_OFS, rv);
      chk("freeze", rv - m, 32'(($time - t0) / 50 - 20));
      i_cpu.wr(`TMU_CTRL3_OFS, 32'h0);
      // watchdog: irq at 2, reset at 3, wrong key then real feed
      chk("wd idle", {31'h0, nmi | wrst}, 32'h0);
      i_cpu.wr(`TMU_WDCTRL_OFS, 32'h00030021);
      wait_hi(nmi, 25000);
      i_cpu.wr(`TMU_WDFEED_OFS, 32'h00001234);
      repeat (2) @(posedge clk);
      chk("bad feed", {31'h0, nmi}, 32'h1);
      i_cpu.feed();
      repeat (2) @(posedge clk);
      chk("feed", {31'h0, nmi}, 32'h0);
      wait_hi(wrst, 30000);
      i_cpu.rd(`TMU_WDCTRL_OFS, rv);
      chk("wd off", {31'h0, rv[0]}, 32'h0);
      end_sim;
   end
endmodule
bind tmu_top tmu_top_asserts i_chk (.REF_CLK_I(REF_CLK_I),
   .RSTN_I(RSTN_I), .CE_I(CE_I), .SLOW_CLK_I(SLOW_CLK_I), .HSEL_I(HSEL_I),
   .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
   .HSIZE_I(HSIZE_I), .HREADY_I(HREADY_I), .HWDATA_I(HWDATA_I),
   .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .TIMER_OUT_O(TIMER_OUT_O), .TIMER_IRQ_O(TIMER_IRQ_O),
   .WD_NMI_O(WD_NMI_O), .WD_RESET_O(WD_RESET_O), .SYS_TICK_O(SYS_TICK_O));
